// ### dcsbc_map.svh
// Register offsets, field positions, reset values and timing in ns
`ifndef DCSBC_MAP_SVH
`define DCSBC_MAP_SVH

// ============================================================
// Register indices (printed offsets are indices, addr = 4 * index)
`define DCSBC_IDX_ADD_CTRL1    8'h17
`define DCSBC_IDX_PWR_MGMT1    8'h19
`define DCSBC_IDX_ANTI_POP     8'h1c
`define DCSBC_IDX_IN_BIAS      8'h23
`define DCSBC_IDX_SERVO1       8'h3d
`define DCSBC_IDX_SERVO4       8'h40
`define DCSBC_IDX_STATUS       8'h41

// ============================================================
// Field positions
`define DCSBC_ADC_OS_BIT       5
`define DCSBC_REF_SEL_LO       7
`define DCSBC_BIAS_EN_BIT      6
`define DCSBC_SU_BIAS_BIT      4
`define DCSBC_BUF_REF_BIT      3
`define DCSBC_RAMP_BIT         2
`define DCSBC_MIX_BIAS_LO      3
`define DCSBC_AMP_BIAS_LO      0
`define DCSBC_L_SERVO_EN_BIT   7
`define DCSBC_L_SYNC_BIT       4
`define DCSBC_R_SERVO_EN_BIT   3
`define DCSBC_R_SYNC_BIT       0
`define DCSBC_COUNT_LO         7
`define DCSBC_ST_L_BUSY_BIT    1
`define DCSBC_ST_R_BUSY_BIT    0

// ============================================================
// Reset values and limits
`define DCSBC_COUNT_RST        7'h10
`define DCSBC_COUNT_MIN        7'h10
`define DCSBC_REF_SEL_RST      2'h0
`define DCSBC_MIX_BIAS_RST     3'h0
`define DCSBC_AMP_BIAS_RST     3'h4

// ============================================================
// Timing: one correction update period and the clock period, in ns
`define DCSBC_UPDATE_NS        1000
`define DCSBC_CLK_NS           5

`endif

// ### dcsbc_pkg.sv
// Types shared by the offset-servo sync and bias control block
package dcsbc_pkg;
  // Sync sequencer states, one per channel
  typedef enum logic [1:0] {
    DCSBC_IDLE = 2'b00,
    DCSBC_WAIT = 2'b01,
    DCSBC_STEP = 2'b10
  } dcsbc_state_t;
endpackage

// ### dcsbc_props.sv
// Port-level checks for the offset-servo sync and bias block
`timescale 1ns/1ps
`default_nettype none
module dcsbc_props (
  // Clock, reset and APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // Controls
  input wire logic [1:0]  reference_divider_select,
  input wire logic        startup_bias_enable,
  input wire logic        adc_oversample_select,
  input wire logic [2:0]  input_mixer_bias_select,
  input wire logic [2:0]  input_amp_bias_select,
  input wire logic        left_hp_servo_enable,
  input wire logic        right_hp_servo_enable,
  input wire logic        left_hp_correction_update,
  input wire logic        right_hp_correction_update,
  input wire logic        left_hp_sync_busy,
  input wire logic        right_hp_sync_busy
);
  // ==========================================================
  // Completed write strobe
  logic wr;
  assign wr = psel & penable & pready & pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Assertions
  a_ref_sel_wr: assert property (
    wr && paddr == 12'h064 |=> reference_divider_select == $past(pwdata[8:7]))
    else $error("divider select not taken from write");
  a_su_bias_wr: assert property (
    wr && paddr == 12'h070 |=> startup_bias_enable == $past(pwdata[4]))
    else $error("startup bias not taken from write");
  a_adc_os_wr: assert property (
    wr && paddr == 12'h05c |=> adc_oversample_select == $past(pwdata[5]))
    else $error("oversample select not taken from write");
  a_bias_fields_wr: assert property (
    wr && paddr == 12'h08c |=>
    {input_mixer_bias_select, input_amp_bias_select} == $past(pwdata[5:0]))
    else $error("bias fields not taken from write");
  a_left_sync_start: assert property (
    wr && paddr == 12'h0f4 && pwdata[7] && pwdata[4] && !left_hp_sync_busy
    |-> ##[1:4] left_hp_sync_busy) else $error("left sync did not start");
  a_right_sync_start: assert property (
    wr && paddr == 12'h0f4 && pwdata[3] && pwdata[0] && !right_hp_sync_busy
    |-> ##[1:4] right_hp_sync_busy) else $error("right sync did not start");
  a_pulse_single: assert property (
    left_hp_correction_update |=> !left_hp_correction_update)
    else $error("left update pulse too long");
  a_idle_quiet: assert property (
    $fell(right_hp_sync_busy) |-> !right_hp_correction_update [*4])
    else $error("right update after series end");
  a_abort_bound: assert property (
    $fell(left_hp_servo_enable) |-> ##[0:3] !left_hp_sync_busy)
    else $error("left series not aborted");
  // ==========================================================
  // Main scenario coverage
  c_left_upd: cover property (left_hp_correction_update);
  c_right_upd: cover property (right_hp_correction_update);
  c_abort: cover property ($fell(left_hp_servo_enable) && left_hp_sync_busy);
endmodule
bind dcsbc_top dcsbc_props u_props (.*);
`default_nettype wire

// ### dcsbc_sync_chan.sv
// One headphone channel sync-mode update sequencer
`timescale 1ns/1ps
`default_nettype none
`include "dcsbc_map.svh"

module dcsbc_sync_chan #(
  parameter int UPDATE_CYCLES = 200
) (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic       trigger,
  input  wire logic       servo_enable,
  input  wire logic [6:0] update_count,
  // Status and correction strobe
  output logic            busy,
  output logic            update_pulse
);
  import dcsbc_pkg::*;

  initial
  begin
    if (UPDATE_CYCLES < 1)
      $error("UPDATE_CYCLES must be at least one");
  end

  // ==========================================================
  // State
  typedef struct packed {
    dcsbc_state_t state;   // Sequencer state
    logic [6:0]   left;    // Updates still to perform
    logic [31:0]  timer;   // Cycles within one update period
    logic         pulse;   // Correction update strobe
  } dcsbc_chan_t;

  dcsbc_chan_t s_r;
  dcsbc_chan_t s_nxt;

  // Next state logic
  always_comb
  begin
    s_nxt       = s_r;
    s_nxt.pulse = 1'b0;
    case (s_r.state)
      DCSBC_IDLE:
      begin
        // One series per write, only while the servo is enabled
        if (trigger && servo_enable)
        begin
          // Reserved low codes run the minimum series of sixteen
          s_nxt.left  = (update_count < `DCSBC_COUNT_MIN) ?
                        `DCSBC_COUNT_MIN : update_count;
          s_nxt.timer = 32'h0;
          s_nxt.state = DCSBC_WAIT;
        end
      end
      DCSBC_WAIT:
      begin
        // Long filtering period per update while audio runs
        if (!servo_enable)
          s_nxt.state = DCSBC_IDLE;
        else if (s_r.timer == 32'(UPDATE_CYCLES - 1))
          s_nxt.state = DCSBC_STEP;
        else
          s_nxt.timer = s_r.timer + 32'h1;
      end
      DCSBC_STEP:
      begin
        // No correction lands once the servo is switched off
        if (!servo_enable)
          s_nxt.state = DCSBC_IDLE;
        else
        begin
          // Apply one correction, then return idle when done
          s_nxt.pulse = 1'b1;
          s_nxt.left  = s_r.left - 7'h1;
          s_nxt.timer = 32'h0;
          s_nxt.state = (s_r.left == 7'h1) ? DCSBC_IDLE : DCSBC_WAIT;
        end
      end
      default:
        s_nxt.state = DCSBC_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_r <= '{state: DCSBC_IDLE, left: 7'h0, timer: 32'h0, pulse: 1'b0};
    else
      s_r <= s_nxt;
  end

  // Busy covers the final update strobe, so status never drops early
  assign busy         = (s_r.state != DCSBC_IDLE) || s_r.pulse;
  assign update_pulse = s_r.pulse;
endmodule
`default_nettype wire

// ### dcsbc_top.sv
// Offset-servo sync control and reference/bias register bank, APB slave
// What this block does
// - Left sync write starts left correction series
// - Right sync write starts right correction series
// - Shared update count, reset sixteen, max 127
// - Sync mode only on headphone channels
// - Sync series runs long, filtering audio
// - Reference divider select, reset off, four codes
// - Start-up bias enable bit, reset zero
// - Buffered reference holds disabled paths mid-rail
// - ADC oversampling select, reset low power
// - Mixer bias field, reset double bias
// - Amplifier bias field, reset two-thirds
// - Servo enable gates each channel's correction
`timescale 1ns/1ps
`default_nettype none
`include "dcsbc_map.svh"

module dcsbc_top #(
  parameter int UPDATE_NS = `DCSBC_UPDATE_NS
) (
  // APB clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB request
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  // APB answer
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Reference and bias controls
  output logic [1:0]       reference_divider_select,
  output logic             reference_soft_ramp_enable,
  output logic             normal_bias_enable,
  output logic             startup_bias_enable,
  output logic             buffered_reference_enable,
  output logic             adc_oversample_select,
  output logic [2:0]       input_mixer_bias_select,
  output logic [2:0]       input_amp_bias_select,
  // Headphone servo controls
  output logic             left_hp_servo_enable,
  output logic             right_hp_servo_enable,
  output logic             left_hp_correction_update,
  output logic             right_hp_correction_update,
  output logic             left_hp_sync_busy,
  output logic             right_hp_sync_busy
);
  import dcsbc_pkg::*;

  // Cycles per correction update, at least one
  localparam int UPDATE_CYCLES_RAW = UPDATE_NS / `DCSBC_CLK_NS;
  localparam int UPDATE_CYCLES =
    (UPDATE_CYCLES_RAW < 1) ? 1 : UPDATE_CYCLES_RAW;

  initial
  begin
    if (UPDATE_NS < 1)
      $error("UPDATE_NS must be positive");
  end

  // ==========================================================
  // Helpers
  // Byte address of a register index
  function automatic logic [11:0] reg_addr(input logic [7:0] idx);
    reg_addr = {2'b00, idx, 2'b00};
  endfunction

  // ==========================================================
  // State
  typedef struct packed {
    logic        ready;      // APB answer phase
    logic [31:0] rdata;      // Read data
    logic        err;        // Unmapped address
    logic [1:0]  ref_sel;    // Divider select
    logic        bias_en;    // Normal bias
    logic        su_bias;    // Start-up bias
    logic        buf_ref;    // Buffered reference
    logic        ramp;       // Soft ramp
    logic        adc_os;     // Oversampling
    logic [2:0]  mix_bias;   // Mixer bias
    logic [2:0]  amp_bias;   // Amplifier bias
    logic        l_en;       // Left servo enable
    logic        r_en;       // Right servo enable
    logic        l_trig;     // Left trigger pulse
    logic        r_trig;     // Right trigger pulse
    logic [6:0]  count;      // Updates per series
    logic        l_upd;      // Registered left update
    logic        r_upd;      // Registered right update
    logic        l_busy;     // Registered left busy
    logic        r_busy;     // Registered right busy
  } dcsbc_regs_t;

  dcsbc_regs_t s_r;
  dcsbc_regs_t s_nxt;

  logic l_busy_w;   // Left sequencer running
  logic r_busy_w;   // Right sequencer running
  logic l_upd_w;    // Left update strobe
  logic r_upd_w;    // Right update strobe
  logic access;     // APB access phase cycle
  logic hit;        // Address decodes to a register

  assign access = psel && penable && !s_r.ready;

  // ==========================================================
  // Register decode, write and read
  always_comb
  begin
    s_nxt        = s_r;
    s_nxt.ready  = access;
    s_nxt.l_trig = 1'b0;
    s_nxt.r_trig = 1'b0;
    s_nxt.l_upd  = l_upd_w;
    s_nxt.r_upd  = r_upd_w;
    s_nxt.l_busy = l_busy_w;
    s_nxt.r_busy = r_busy_w;
    hit          = 1'b1;
    s_nxt.rdata  = 32'h0;
    case (paddr)
      reg_addr(`DCSBC_IDX_ADD_CTRL1):
        s_nxt.rdata[`DCSBC_ADC_OS_BIT] = s_r.adc_os;
      reg_addr(`DCSBC_IDX_PWR_MGMT1):
      begin
        s_nxt.rdata[`DCSBC_REF_SEL_LO +: 2] = s_r.ref_sel;
        s_nxt.rdata[`DCSBC_BIAS_EN_BIT]     = s_r.bias_en;
      end
      reg_addr(`DCSBC_IDX_ANTI_POP):
      begin
        s_nxt.rdata[`DCSBC_SU_BIAS_BIT] = s_r.su_bias;
        s_nxt.rdata[`DCSBC_BUF_REF_BIT] = s_r.buf_ref;
        s_nxt.rdata[`DCSBC_RAMP_BIT]    = s_r.ramp;
      end
      reg_addr(`DCSBC_IDX_IN_BIAS):
      begin
        s_nxt.rdata[`DCSBC_MIX_BIAS_LO +: 3] = s_r.mix_bias;
        s_nxt.rdata[`DCSBC_AMP_BIAS_LO +: 3] = s_r.amp_bias;
      end
      reg_addr(`DCSBC_IDX_SERVO1):
      begin
        // Trigger bits read as zero: they are one-shot
        s_nxt.rdata[`DCSBC_L_SERVO_EN_BIT] = s_r.l_en;
        s_nxt.rdata[`DCSBC_R_SERVO_EN_BIT] = s_r.r_en;
      end
      reg_addr(`DCSBC_IDX_SERVO4):
        s_nxt.rdata[`DCSBC_COUNT_LO +: 7] = s_r.count;
      reg_addr(`DCSBC_IDX_STATUS):
      begin
        s_nxt.rdata[`DCSBC_ST_L_BUSY_BIT] = s_r.l_busy;
        s_nxt.rdata[`DCSBC_ST_R_BUSY_BIT] = s_r.r_busy;
      end
      default:
        hit = 1'b0;
    endcase
    if (!access || pwrite)
      s_nxt.rdata = 32'h0;
    s_nxt.err = access && !hit;
    if (access && pwrite)
    begin
      case (paddr)
        reg_addr(`DCSBC_IDX_ADD_CTRL1):
          s_nxt.adc_os = pwdata[`DCSBC_ADC_OS_BIT];
        reg_addr(`DCSBC_IDX_PWR_MGMT1):
        begin
          s_nxt.ref_sel = pwdata[`DCSBC_REF_SEL_LO +: 2];
          s_nxt.bias_en = pwdata[`DCSBC_BIAS_EN_BIT];
        end
        reg_addr(`DCSBC_IDX_ANTI_POP):
        begin
          s_nxt.su_bias = pwdata[`DCSBC_SU_BIAS_BIT];
          s_nxt.buf_ref = pwdata[`DCSBC_BUF_REF_BIT];
          s_nxt.ramp    = pwdata[`DCSBC_RAMP_BIT];
        end
        reg_addr(`DCSBC_IDX_IN_BIAS):
        begin
          // Reserved codes are stored as written
          s_nxt.mix_bias = pwdata[`DCSBC_MIX_BIAS_LO +: 3];
          s_nxt.amp_bias = pwdata[`DCSBC_AMP_BIAS_LO +: 3];
        end
        reg_addr(`DCSBC_IDX_SERVO1):
        begin
          s_nxt.l_en   = pwdata[`DCSBC_L_SERVO_EN_BIT];
          s_nxt.r_en   = pwdata[`DCSBC_R_SERVO_EN_BIT];
          s_nxt.l_trig = pwdata[`DCSBC_L_SYNC_BIT];
          s_nxt.r_trig = pwdata[`DCSBC_R_SYNC_BIT];
        end
        reg_addr(`DCSBC_IDX_SERVO4):
          s_nxt.count = pwdata[`DCSBC_COUNT_LO +: 7];
        default:
          s_nxt.count = s_r.count;
      endcase
    end
  end

  // ==========================================================
  // Register state, defined after reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r          <= '0;
      s_r.ref_sel  <= `DCSBC_REF_SEL_RST;
      s_r.mix_bias <= `DCSBC_MIX_BIAS_RST;
      s_r.amp_bias <= `DCSBC_AMP_BIAS_RST;
      s_r.count    <= `DCSBC_COUNT_RST;
    end
    else
      s_r <= s_nxt;
  end

  // ==========================================================
  // Sync sequencers: headphone channels only, inputs have none
  dcsbc_sync_chan #(
    .UPDATE_CYCLES (UPDATE_CYCLES)
  ) u_left (
    .pclk         (pclk),
    .presetn      (presetn),
    .trigger      (s_r.l_trig),
    .servo_enable (s_r.l_en),
    .update_count (s_r.count),
    .busy         (l_busy_w),
    .update_pulse (l_upd_w)
  );

  dcsbc_sync_chan #(
    .UPDATE_CYCLES (UPDATE_CYCLES)
  ) u_right (
    .pclk         (pclk),
    .presetn      (presetn),
    .trigger      (s_r.r_trig),
    .servo_enable (s_r.r_en),
    .update_count (s_r.count),
    .busy         (r_busy_w),
    .update_pulse (r_upd_w)
  );

  // ==========================================================
  // Outputs, all from flip-flops
  assign pready                     = s_r.ready;
  assign prdata                     = s_r.rdata;
  assign pslverr                    = s_r.err;
  assign reference_divider_select   = s_r.ref_sel;
  assign reference_soft_ramp_enable = s_r.ramp;
  assign normal_bias_enable         = s_r.bias_en;
  assign startup_bias_enable        = s_r.su_bias;
  assign buffered_reference_enable  = s_r.buf_ref;
  assign adc_oversample_select      = s_r.adc_os;
  assign input_mixer_bias_select    = s_r.mix_bias;
  assign input_amp_bias_select      = s_r.amp_bias;
  assign left_hp_servo_enable       = s_r.l_en;
  assign right_hp_servo_enable      = s_r.r_en;
  assign left_hp_correction_update  = s_r.l_upd;
  assign right_hp_correction_update = s_r.r_upd;
  assign left_hp_sync_busy          = s_r.l_busy;
  assign right_hp_sync_busy         = s_r.r_busy;
endmodule
`default_nettype wire

// ### dcsbc_top_bench.sv
// Self-checking bench for the offset-servo sync and bias block
`timescale 1ns/1ps
`default_nettype none
module dcsbc_top_bench;
  // ==========================================================
  // Signals
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, q;
  logic pready, pslverr, e, lu, ru, lb, rb, le, re;
  logic [31:0] prdata;
  logic [1:0] rs;
  logic rr, nb, sb, bb, ao;
  logic [2:0] mb, ab;
  int bad_count = 0, num_checks = 0, lp = 0, rp = 0, l0, r0;
  // Short update period keeps each series fast
  dcsbc_top #(.UPDATE_NS(20)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .reference_divider_select(rs), .reference_soft_ramp_enable(rr),
    .normal_bias_enable(nb), .startup_bias_enable(sb),
    .buffered_reference_enable(bb), .adc_oversample_select(ao),
    .input_mixer_bias_select(mb), .input_amp_bias_select(ab),
    .left_hp_servo_enable(le), .right_hp_servo_enable(re),
    .left_hp_correction_update(lu), .right_hp_correction_update(ru),
    .left_hp_sync_busy(lb), .right_hp_sync_busy(rb));
  initial forever #2.5 pclk = ~pclk;
  // Count correction pulses per channel
  always @(posedge pclk)
  begin
    if (lu === 1'b1) lp <= lp + 1;
    if (ru === 1'b1) rp <= rp + 1;
  end
  // ==========================================================
  // Tasks
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] x, logic [31:0] g);
    num_checks++;
    if (g !== x)
    begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", nm, x, g);
    end
  endtask
  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(bit w, logic [11:0] a, logic [31:0] d);
    int n;
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
    if (n >= 50) begin bad_count++; end_sim(); end
    @(posedge pclk);
  endtask
  // Bounded wait for both series to finish
  task automatic idle;
    int n;
    n = 0;
    // Busy shows up two edges after the trigger write completes
    repeat (2) @(posedge pclk);
    while ((lb !== 1'b0 || rb !== 1'b0) && n < 3000)
    begin @(posedge pclk); n++; end
    if (n >= 3000) begin bad_count++; end_sim(); end
  endtask
  // Trigger a series and compare pulse counts
  task automatic sync(logic [31:0] d, int xl, int xr);
    l0 = lp; r0 = rp;
    apb(1, 12'h0f4, d);
    idle();
    chk("left pulses", xl, lp - l0);
    chk("right pulses", xr, rp - r0);
  endtask
  // ==========================================================
  // Sequence
  logic [11:0] ra [7] = '{12'h05c, 12'h064, 12'h070, 12'h08c, 12'h0f4,
                          12'h100, 12'h104};
  logic [31:0] rv [7] = '{0, 0, 0, 32'h4, 0, 32'h800, 0};
  logic [5:0] bc [4] = '{6'h24, 6'h1c, 6'h04, 6'h00};
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    foreach (ra[i]) begin apb(0, ra[i], 0); chk("reset", rv[i], q); end
    chk("amp bias port", 3'h4, ab);
    // Soft ramp goes on before any divider code is chosen
    apb(1, 12'h070, 32'h1c);
    chk("anti pop port", 3'h7, {sb, bb, rr});
    // Normal bias only ever rides with the reference on
    for (int i = 0; i < 4; i++)
    begin
      apb(1, 12'h064, ((i != 0) ? 32'h40 : 32'h0) | (i << 7));
      apb(0, 12'h064, 0);
      chk("pwr mgmt", ((i != 0) ? 32'h40 : 32'h0) | (i << 7), q);
      chk("divider port", {i[1:0], i != 0}, {rs, nb});
    end
    apb(1, 12'h064, 32'hc0);
    chk("normal divider", 3'h3, {rs, nb});
    apb(1, 12'h05c, 32'h20);
    apb(0, 12'h05c, 0);
    chk("oversample reg", 32'h20, q);
    chk("oversample port", 1, ao);
    // Only the recommended input bias combinations are used
    foreach (bc[i])
    begin
      apb(1, 12'h08c, bc[i]);
      apb(0, 12'h08c, 0);
      chk("bias reg", bc[i], q);
      chk("bias ports", bc[i], {mb, ab});
    end
    apb(0, 12'h200, 0);
    chk("unmapped err", 1, e);
    chk("unmapped data", 0, q);
    apb(1, 12'h0f4, 32'h99);
    apb(0, 12'h104, 0);
    chk("status busy", 2'h3, q[1:0]);
    chk("busy ports", 2'h3, {lb, rb});
    idle();
    apb(0, 12'h0f4, 0);
    chk("servo readback", 32'h88, q);
    chk("servo ports", 2'h3, {le, re});
    // Clock runs throughout; resync as after a large gain step
    sync(32'h99, 16, 16);
    apb(1, 12'h100, 32'h11 << 7);
    sync(32'h98, 17, 0);
    apb(1, 12'h100, 32'h7f << 7);
    sync(32'h89, 0, 127);
    apb(1, 12'h100, 32'h05 << 7);
    sync(32'h09, 0, 16);
    sync(32'h11, 0, 0);
    l0 = lp;
    apb(1, 12'h0f4, 32'h90);
    apb(1, 12'h0f4, 32'h00);
    idle();
    chk("aborted short", 1, (lp - l0) < 16);
    end_sim();
  end
endmodule
`default_nettype wire
